// *** rtl/vcpac_pkg.sv ***
// Shared constants and types for the channel 0 arbitration control and status block.
package vcpac_pkg;

  // Register bus geometry.
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;

  // Register byte offsets.
  localparam logic [11:0] CAP_OFF       = 12'h0210;
  localparam logic [11:0] CTL_OFF       = 12'h0214;
  localparam logic [11:0] STS_OFF       = 12'h0218;
  localparam logic [11:0] TBL_OFF       = 12'h0220;
  localparam logic [11:0] TBL_MASK      = 12'h0FF3;
  localparam int          TBL_IDX_LSB   = 2;
  localparam int          TBL_IDX_W     = 2;
  localparam int          TBL_WORDS     = 4;

  // Field positions.
  localparam int          CAP_TBLOFF_LSB = 24;
  localparam int          CTL_LOAD_BIT  = 16;
  localparam int          CTL_SEL_LSB   = 17;
  localparam int          SEL_W         = 3;
  localparam int          CTL_ID_LSB    = 24;
  localparam int          CTL_EN_BIT    = 31;
  localparam int          STS_PEND_BIT  = 16;
  localparam int          STS_NEG_BIT   = 17;

  // Fixed field values.
  localparam logic [7:0]  CAP_UP        = 8'h03;
  localparam logic [7:0]  CAP_DN        = 8'h01;
  localparam logic [7:0]  TBLOFF_UP     = 8'h02;
  localparam logic [7:0]  TBLOFF_DN     = 8'h00;
  localparam logic [2:0]  CHANNEL_ID    = 3'h0;
  localparam logic        CHANNEL_EN    = 1'b1;
  localparam logic [2:0]  SEL_RESET     = 3'h0;

  // Arbitration schemes, numbered by their capability bit.
  localparam logic [2:0]  SCHEME_FIXED_RR = 3'h0;
  localparam logic [2:0]  SCHEME_WRR32    = 3'h1;

  // Arbitration table layout and port validity.
  localparam int          PHASES        = 32;
  localparam int          PHASE_W       = 5;
  localparam int          PORT_W        = 4;
  localparam int          TBL_W         = PHASES * PORT_W;
  localparam logic [15:0] VALID_PORTS   = 16'h0015;
  localparam logic [TBL_W-1:0] TBL_RESET =
    128'h4321_7654_3217_6543_2176_5432_1765_4321;

  // Cycles the table load spends before committing.
  localparam logic [2:0]  LOAD_CYCLES   = 3'h4;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_BUSY = 2'b10
  } vcpac_load_t;

endpackage

// *** rtl/vcpac_tbl_if.sv ***
// Signals between the register file, the table store and the arbiter.
`timescale 1ns/1ns
interface vcpac_tbl_if;
  import vcpac_pkg::*;

  logic                 tbl_wr;
  logic [TBL_IDX_W-1:0] tbl_idx;
  logic [DATA_W-1:0]    tbl_wdata;
  logic                 load_req;
  logic                 pending;
  logic                 loading;
  logic [TBL_W-1:0]     shadow;
  logic [TBL_W-1:0]     live;
  logic [SEL_W-1:0]     scheme;

  modport regs  (output tbl_wr, tbl_idx, tbl_wdata, load_req, scheme,
                 input  pending, loading, shadow);
  modport store (input  tbl_wr, tbl_idx, tbl_wdata, load_req,
                 output pending, loading, shadow, live);
  modport arb   (input  live, scheme);
endinterface

// *** rtl/vcpac_table.sv ***
// Arbitration table store: software copy, live copy and the load sequence.
`timescale 1ns/1ns
module vcpac_table
  import vcpac_pkg::*;
(
  // Clock and reset.
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Table traffic.
  vcpac_tbl_if.store tb
);

  vcpac_load_t      state_q;
  vcpac_load_t      state_d;
  logic [2:0]       cnt_q;
  logic [TBL_W-1:0] shadow_q;
  logic [TBL_W-1:0] live_q;
  logic             pend_q;
  wire              finish = (state_q == LD_BUSY) && (cnt_q == LOAD_CYCLES - 3'h1);

  // Software copy, one word per register.
  for (genvar w = 0; w < TBL_WORDS; w++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        shadow_q[w*DATA_W +: DATA_W] <= TBL_RESET[w*DATA_W +: DATA_W];
      end else if (tb.tbl_wr && tb.tbl_idx == TBL_IDX_W'(w)) begin
        shadow_q[w*DATA_W +: DATA_W] <= tb.tbl_wdata;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LD_IDLE: if (tb.load_req) state_d = LD_BUSY;
      LD_BUSY: if (finish) state_d = LD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LD_IDLE;
      cnt_q   <= 3'h0;
      live_q  <= TBL_RESET;
      pend_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == LD_BUSY) ? cnt_q + 3'h1 : 3'h0;
      if (finish) live_q <= shadow_q;
      if (tb.tbl_wr) pend_q <= 1'b1;
      else if (finish) pend_q <= 1'b0;
    end
  end

  assign tb.shadow  = shadow_q;
  assign tb.live    = live_q;
  assign tb.pending = pend_q;
  assign tb.loading = (state_q == LD_BUSY);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_load_start;
    (state_q == LD_IDLE) && tb.load_req;
  endsequence
  sequence s_load_run;
    $stable(live_q) [*4] ##1 (live_q == $past(shadow_q));
  endsequence

  chk_load_commit: assert property (s_load_start |=> s_load_run)
    else $error("table load did not commit after four busy cycles");
  chk_live_switch: assert property (!$stable(live_q) |-> $past(finish))
    else $error("live table changed outside a load commit");
  chk_pend_set: assert property (tb.tbl_wr |=> pend_q)
    else $error("table write did not set pending");
  chk_pend_clear: assert property (finish && !tb.tbl_wr |=> !pend_q)
    else $error("pending not cleared at load completion");

endmodule

// *** rtl/vcpac_arbiter.sv ***
// Port arbiter driven by the live table or by fixed round robin.
`timescale 1ns/1ns
module vcpac_arbiter
  import vcpac_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Table and scheme.
  vcpac_tbl_if.arb               ta,
  // Grant side.
  input  wire logic              step_in,
  output logic       [PORT_W-1:0] port_out,
  output logic                   valid_out
);

  logic [PHASE_W-1:0] phase_q;
  logic [PORT_W-1:0]  port_q;
  logic               valid_q;
  logic [PORT_W-1:0]  ent_port [PHASES];
  logic [PHASES-1:0]  ent_ok;
  logic [PHASE_W-1:0] nxt_phase;
  logic               phase_found;
  logic [PORT_W-1:0]  nxt_id;
  logic [PHASE_W-1:0] pi;
  logic [PORT_W-1:0]  ii;

  for (genvar i = 0; i < PHASES; i++) begin : g_ent
    assign ent_port[i] = ta.live[i*PORT_W +: PORT_W];
    assign ent_ok[i]   = VALID_PORTS[ent_port[i]];
  end

  // Next usable phase; invalid ports are passed over in the same cycle.
  always_comb begin
    nxt_phase   = phase_q;
    phase_found = 1'b0;
    pi          = phase_q;
    for (int k = 1; k <= PHASES; k++) begin
      pi = phase_q + PHASE_W'(k);
      if (!phase_found && ent_ok[pi]) begin
        nxt_phase   = pi;
        phase_found = 1'b1;
      end
    end
  end

  // Next valid port for fixed round robin.
  always_comb begin
    nxt_id = port_q;
    ii     = port_q;
    for (int k = 16; k >= 1; k--) begin
      ii = port_q + PORT_W'(k);
      if (VALID_PORTS[ii]) nxt_id = ii;
    end
  end

  wire use_tbl = (ta.scheme == SCHEME_WRR32);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      port_q  <= '0;
      valid_q <= 1'b0;
    end else if (step_in) begin
      phase_q <= use_tbl ? nxt_phase : phase_q;
      port_q  <= use_tbl ? ent_port[nxt_phase] : nxt_id;
      valid_q <= use_tbl ? phase_found : 1'b1;
    end
  end

  assign port_out  = port_q;
  assign valid_out = valid_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_skip_invalid: assert property (step_in |=> !valid_q || VALID_PORTS[port_q])
    else $error("arbiter granted an invalid port");

endmodule

// *** rtl/vcpac_top.sv ***
// Channel 0 arbitration control and status registers with table load and arbiter.
// Overview of operation
// - Writing one to the load bit copies the software table into the arbiter.
// - Writing zero to the load bit does nothing.
// - Only the upstream instance acts on the load command.
// - Load acts only when the selected scheme uses the table.
// - Channel identifier is read-only zero.
// - Channel enable is read-only one.
// - Any table write sets the table-pending bit.
// - Table-pending clears once the load has finished.
// - Downstream instances read table-pending as zero.
// - Table-pending means something only under a table-based scheme.
// - Negotiation-pending tracks flow control init, clears on leaving FC_INIT2.
// - Negotiation-pending matters only with link active and channel enabled; the read is gated by channel enable only, DL_ACTIVE_IN is unused.
// - Capability bit 0 fixed round robin, bit 1 weighted; downstream only bit 0.
// - Table entries naming an invalid port are skipped without delay.
`timescale 1ns/1ns
module vcpac_top
  import vcpac_pkg::*;
#(
  parameter bit IS_UPSTREAM = 1'b1
)(
  // Clock and reset.
  input  wire logic              CLK_SYS_IN,
  input  wire logic              NRST_IN,
  // Register port.
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RDATA_OUT,
  // Link status.
  input  wire logic              DL_ACTIVE_IN,
  input  wire logic              FC_INIT2_IN,
  // Arbiter grant.
  input  wire logic              ARB_STEP_IN,
  output logic      [PORT_W-1:0] ARB_PORT_OUT,
  output logic                   ARB_VALID_OUT
);

  logic [1:0]        rst_sync_q;
  logic              rst_n;
  logic [SEL_W-1:0]  sel_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_word;
  logic              neg_q;
  logic              fc_prev_q;

  vcpac_tbl_if tif ();

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Address decode.
  wire hit_cap = (ADDR_IN == CAP_OFF);
  wire hit_ctl = (ADDR_IN == CTL_OFF);
  wire hit_sts = (ADDR_IN == STS_OFF);
  wire hit_tbl = ((ADDR_IN & TBL_MASK) == TBL_OFF);
  wire up      = IS_UPSTREAM;

  // Load command qualification.
  wire load_bit   = WR_IN && hit_ctl && WDATA_IN[CTL_LOAD_BIT];
  wire uses_table = (sel_q == SCHEME_WRR32);
  wire load_ok    = load_bit && up && uses_table;

  assign tif.load_req  = load_ok;
  assign tif.tbl_wr    = WR_IN && hit_tbl && up;
  assign tif.tbl_idx   = ADDR_IN[TBL_IDX_LSB +: TBL_IDX_W];
  assign tif.tbl_wdata = WDATA_IN;
  assign tif.scheme    = sel_q;

  // Scheme select is stored as written; software keeps it legal.
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= SEL_RESET;
    end else if (WR_IN && hit_ctl) begin
      sel_q <= WDATA_IN[CTL_SEL_LSB +: SEL_W];
    end
  end

  // Negotiation pending follows the FC_INIT2 state.
  wire fc_enter = FC_INIT2_IN && !fc_prev_q;
  wire fc_leave = !FC_INIT2_IN && fc_prev_q;

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      fc_prev_q <= 1'b0;
      neg_q     <= 1'b0;
    end else begin
      fc_prev_q <= FC_INIT2_IN;
      if (fc_enter) neg_q <= 1'b1;
      else if (fc_leave) neg_q <= 1'b0;
    end
  end

  // Read words.
  wire [7:0]        cap_bits = up ? CAP_UP : CAP_DN;
  wire [7:0]        tbl_off  = up ? TBLOFF_UP : TBLOFF_DN;
  wire [DATA_W-1:0] cap_word = (DATA_W'(tbl_off) << CAP_TBLOFF_LSB) | DATA_W'(cap_bits);
  wire [DATA_W-1:0] ctl_word = (DATA_W'(CHANNEL_EN) << CTL_EN_BIT)
                             | (DATA_W'(CHANNEL_ID) << CTL_ID_LSB)
                             | (DATA_W'(sel_q) << CTL_SEL_LSB);
  wire              pend_rd  = up && tif.pending;
  wire              neg_rd   = neg_q && CHANNEL_EN;
  wire [DATA_W-1:0] sts_word = (DATA_W'(pend_rd) << STS_PEND_BIT)
                             | (DATA_W'(neg_rd) << STS_NEG_BIT);
  wire [DATA_W-1:0] tbl_word = up ? tif.shadow[tif.tbl_idx*DATA_W +: DATA_W] : '0;

  always_comb begin
    rd_word = '0;
    if (hit_cap) rd_word = cap_word;
    if (hit_ctl) rd_word = ctl_word;
    if (hit_sts) rd_word = sts_word;
    if (hit_tbl) rd_word = tbl_word;
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= RD_IN ? rd_word : '0;
    end
  end
  assign RDATA_OUT = rdata_q;

  vcpac_table u_table (
    .clk   (CLK_SYS_IN),
    .rst_n (rst_n),
    .tb    (tif.store)
  );

  vcpac_arbiter u_arb (
    .clk       (CLK_SYS_IN),
    .rst_n     (rst_n),
    .ta        (tif.arb),
    .step_in   (ARB_STEP_IN),
    .port_out  (ARB_PORT_OUT),
    .valid_out (ARB_VALID_OUT)
  );

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n);

  chk_load_issue: assert property (load_bit && up && uses_table && !tif.loading
      |=> tif.loading)
    else $error("load command did not start the table load");
  chk_zero_noload: assert property (WR_IN && hit_ctl && !WDATA_IN[CTL_LOAD_BIT]
      && !tif.loading |=> !tif.loading)
    else $error("zero write to load bit started a load");
  chk_down_noload: assert property (!up |-> !tif.loading && $stable(tif.live))
    else $error("downstream instance changed its arbitration table");
  chk_scheme_gate: assert property (load_bit && !uses_table && !tif.loading
      |=> !tif.loading)
    else $error("load started under a scheme without table");
  chk_ctl_fixed: assert property (RD_IN && hit_ctl |=>
      RDATA_OUT[CTL_ID_LSB +: SEL_W] == CHANNEL_ID && RDATA_OUT[CTL_EN_BIT])
    else $error("channel id or enable read wrong");
  chk_down_pend: assert property (!up && RD_IN && hit_sts |=> !RDATA_OUT[STS_PEND_BIT])
    else $error("downstream pending read as one");
  chk_pend_read: assert property (tif.tbl_wr ##1 !tif.loading
      ##1 RD_IN && hit_sts |=> RDATA_OUT[STS_PEND_BIT])
    else $error("pending not visible after table write");
  chk_neg_clear: assert property (fc_leave |=> !neg_q)
    else $error("negotiation pending kept after leaving FC_INIT2");
  chk_cap_read: assert property (RD_IN && hit_cap |=>
      RDATA_OUT[SCHEME_WRR32] == up && RDATA_OUT[SCHEME_FIXED_RR])
    else $error("capability bits read wrong");

endmodule

// *** bench/vcpac_tb.sv ***
// Self-checking bench for the channel 0 arbitration control and status block.
`timescale 1ns/1ns
module testbench;
  import vcpac_pkg::*;

  logic              clk;
  logic              nrst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic              dn_on;
  logic              fc;
  logic              step;
  logic [DATA_W-1:0] rdata_up;
  logic [DATA_W-1:0] rdata_dn;
  logic [PORT_W-1:0] port_up;
  logic [PORT_W-1:0] port_dn;
  logic              valid_up;
  logic              valid_dn;
  logic [DATA_W-1:0] ru;
  logic [DATA_W-1:0] rdn;
  logic [DATA_W-1:0] tbl [TBL_WORDS];
  logic [DATA_W-1:0] rnd;
  logic [PORT_W-1:0] prev_port;
  logic [PORT_W-1:0] new_port;
  logic [SEL_W-1:0]  sel;
  logic              ok;
  integer            seed;
  integer            fails;
  integer            check_count;
  integer            ph;

  vcpac_top #(.IS_UPSTREAM(1'b1)) u_dut (
    .CLK_SYS_IN(clk), .NRST_IN(nrst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata_up), .DL_ACTIVE_IN(1'b1),
    .FC_INIT2_IN(fc), .ARB_STEP_IN(step), .ARB_PORT_OUT(port_up),
    .ARB_VALID_OUT(valid_up));

  vcpac_top #(.IS_UPSTREAM(1'b0)) u_dut_dn (
    .CLK_SYS_IN(clk), .NRST_IN(nrst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr & dn_on), .RD_IN(rd), .RDATA_OUT(rdata_dn), .DL_ACTIVE_IN(1'b1),
    .FC_INIT2_IN(fc), .ARB_STEP_IN(step), .ARB_PORT_OUT(port_dn),
    .ARB_VALID_OUT(valid_dn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] exp_ctl(input logic [2:0] s);
    return {1'b1, 11'h000, s, 17'h0_0000};
  endfunction

  function automatic logic [31:0] tbl_word(input int w, input int p, input logic [3:0] port,
                                           input logic [31:0] fill);
    logic [31:0] v;
    v = fill;
    if (w == p / 8) begin
      v[4*(p%8) +: 4] = port;
    end
    return v;
  endfunction

  task automatic close_out();
    $display("Counts: checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count = check_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    dn_on <= (a != CTL_OFF) || (d[19:17] == 3'h0);
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    ru  = rdata_up;
    rdn = rdata_dn;
  endtask

  task automatic step_arb(input logic exact, input logic [3:0] exp_up);
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    @(negedge clk);
    if (exact) begin
      cmp({27'h0, valid_up, port_up}, {27'h0, 1'b1, exp_up}, "grant upstream");
    end else begin
      cmp({31'h0, valid_up & VALID_PORTS[port_up]}, 32'h0000_0001, "grant upstream rr");
    end
    cmp({31'h0, valid_dn & VALID_PORTS[port_dn]}, 32'h0000_0001, "grant downstream");
  endtask

  task automatic poll_pending();
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd_reg(STS_OFF);
      ok = (ru[STS_PEND_BIT] === 1'b0);
    end
  endtask

  initial begin
    #(100 * 20000);
    fails = fails + 1;
    close_out();
  end

  initial begin
    seed = 57663;
    fails = 0;
    check_count = 0;
    nrst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    dn_on = 1'b0;
    fc = 1'b0;
    step = 1'b0;
    repeat (20) @(posedge clk);
    nrst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(CAP_OFF);
    cmp(ru, {TBLOFF_UP, 16'h0000, CAP_UP}, "cap upstream");
    cmp(rdn, {TBLOFF_DN, 16'h0000, CAP_DN}, "cap downstream");
    wr_reg(STS_OFF, 32'hFFFF_FFFF);
    rd_reg(STS_OFF);
    cmp(ru, 32'h0000_0000, "status upstream");
    cmp(rdn, 32'h0000_0000, "status downstream");
    rd_reg(12'h300);
    cmp(ru | rdn, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < TBL_WORDS; i++) begin
      rd_reg(TBL_OFF + 12'(4 * i));
      cmp(ru, TBL_RESET[32*i +: 32], "table reset upstream");
      cmp(rdn, 32'h0000_0000, "table downstream");
    end
    sel = SEL_RESET;
    for (int i = 0; i < 9; i++) begin
      rnd = $random(seed);
      rd_reg(CTL_OFF);
      cmp(ru, exp_ctl(sel), "control upstream");
      cmp(rdn, exp_ctl(3'h0), "control downstream");
      rnd[16] = 1'b0;
      rnd[19:17] = {2'b00, rnd[1]};
      wr_reg(CTL_OFF, rnd);
      sel = rnd[19:17];
    end
    rd_reg(CTL_OFF);
    cmp(ru, exp_ctl(sel), "control upstream last");
    @(posedge clk);
    fc <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(STS_OFF);
    cmp({ru[STS_NEG_BIT], rdn[STS_NEG_BIT]}, 32'h0000_0003, "negotiation set");
    @(posedge clk);
    fc <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(STS_OFF);
    cmp({ru[STS_NEG_BIT], rdn[STS_NEG_BIT]}, 32'h0000_0000, "negotiation clear");
    wr_reg(CTL_OFF, exp_ctl(3'h1));
    for (int it = 0; it < 5; it++) begin
      ph = {$random(seed)} % PHASES;
      new_port = 4'(2 * ({$random(seed)} % 3));
      for (int w = 0; w < TBL_WORDS; w++) begin
        tbl[w] = tbl_word(w, ph, new_port, (it % 2) ? 32'h3535_3535 : 32'h1F1F_1F1F);
        wr_reg(TBL_OFF + 12'(4 * w), tbl[w]);
      end
      rd_reg(STS_OFF);
      cmp({ru[STS_PEND_BIT], rdn[STS_PEND_BIT]}, 32'h0000_0002, "pending after write");
      wr_reg(CTL_OFF, exp_ctl(3'h1));
      rd_reg(STS_OFF);
      cmp({31'h0, ru[STS_PEND_BIT]}, 32'h0000_0001, "pending after zero");
      wr_reg(CTL_OFF, exp_ctl(3'h1) | 32'h0001_0000);
      if (it > 0) begin
        step_arb(1'b1, prev_port);
      end
      poll_pending();
      cmp({31'h0, ok}, 32'h0000_0001, "load completes");
      rd_reg(TBL_OFF + 12'(4 * (ph / 8)));
      cmp(ru, tbl[ph/8], "table readback");
      step_arb(1'b1, new_port);
      step_arb(1'b1, new_port);
      prev_port = new_port;
    end
    wr_reg(TBL_OFF, 32'h4444_4444);
    wr_reg(CTL_OFF, 32'h0000_0000);
    wr_reg(CTL_OFF, 32'h0001_0000);
    repeat (10) @(posedge clk);
    rd_reg(STS_OFF);
    cmp({31'h0, ru[STS_PEND_BIT]}, 32'h0000_0001, "load ignored scheme 0");
    cmp({31'h0, rdn[STS_PEND_BIT]}, 32'h0000_0000, "load ignored downstream");
    for (int i = 0; i < 4; i++) begin
      step_arb(1'b0, 4'h0);
    end
    close_out();
  end
endmodule
